// ### hw/charge_mode_select.sv
// Per-port battery charging mode and line signalling selection
`timescale 1ns/100ps
module charge_mode_select
  import hub_cfg_pkg::*;
#(
  parameter int NPORTS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Configuration
  input wire logic [NPORTS-1:0] port_charge_enable,
  input wire logic auto_charge_disable_n,
  // Port status
  input wire logic [NPORTS-1:0] vbus_above_4v,
  input wire logic [NPORTS-1:0] dcp_device_seen,
  // Results
  output charge_mode_t port_mode [NPORTS],
  output charge_signal_t port_signal [NPORTS]
);

  genvar i;
  generate
    for (i = 0; i < NPORTS; i++)
    begin : g_port
      charge_mode_t next_mode;
      charge_signal_t next_signal;
      // A set enable with high VBUS and auto not disabled is absent from the mode
      // table; auto is kept so that CDP can never appear with auto active
      assign next_mode = !port_charge_enable[i] ? CHG_NONE :
                         !auto_charge_disable_n ? CHG_AUTO :
                         vbus_above_4v[i] ? CHG_CDP : CHG_DCP;
      assign next_signal = (next_mode == CHG_NONE) ? SIG_OFF :
                           (next_mode == CHG_AUTO) ? (dcp_device_seen[i] ? SIG_DCP : SIG_DIVIDER) :
                           (next_mode == CHG_DCP) ? SIG_DCP : SIG_CDP;
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          port_mode[i] <= CHG_NONE;
          port_signal[i] <= SIG_OFF;
        end
        else if (ce)
        begin
          port_mode[i] <= next_mode;
          port_signal[i] <= next_signal;
        end
      end
    end
  endgenerate

endmodule : charge_mode_select

// ### hw/hub_port_charge_power_config.sv
// Hub port charging, power switch and configuration register block
`timescale 1ns/100ps
`include "hub_cfg_params.svh"
module hub_port_charge_power_config
  import hub_cfg_pkg::*;
#(
  parameter int NPORTS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Configuration register port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // One-time memory contents, loaded at start-up
  input wire logic otp_load,
  input wire logic [7:0] otp_addr,
  input wire logic [7:0] otp_data,
  // Vendor request for one-time programming
  input wire logic usb_otp_req,
  input wire logic [7:0] usb_otp_addr,
  input wire logic [7:0] usb_otp_data,
  output logic otp_prog_strobe,
  output logic [7:0] otp_prog_addr,
  output logic [7:0] otp_prog_data,
  output logic otp_prog_reject,
  // Strap pins
  input wire logic power_switching_strap_n,
  input wire logic ganged_strap,
  input wire logic power_enable_polarity_strap,
  input wire logic bus_mode_strap,
  output logic bus_mode,
  output logic strap_done,
  // Power enable pins, doubling as charge enable straps
  input wire logic port1_power_out_charge_strap_in,
  output logic port1_power_out_charge_strap_out,
  output logic port1_power_out_charge_strap_oe,
  input wire logic port2_power_out_charge_strap_in,
  output logic port2_power_out_charge_strap_out,
  output logic port2_power_out_charge_strap_oe,
  // Port power and charging
  input wire logic [NPORTS-1:0] port_power_request,
  input wire logic [NPORTS-1:0] vbus_above_4v_pin,
  input wire logic [NPORTS-1:0] dcp_device_seen,
  output charge_signal_t port_signal [NPORTS],
  output logic divider_level_10w,
  output logic [2:0] power_on_delay_sel,
  output logic [NPORTS-1:0] port_removable,
  // Upstream link speed
  input wire link_speed_t upstream_speed,
  output logic ds_superspeed_enable,
  output logic ds_highspeed_enable
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] vendor_id_low;
  logic [7:0] vendor_id_high;
  logic [7:0] product_id_low;
  logic [7:0] product_id_high;
  logic [7:0] device_config;
  logic [7:0] charge_support;
  logic [7:0] port_removable_config;
  logic [7:0] device_config_two;
  logic [7:0] charge_port_control;

  // ----------------------------------------
  // Strap and VBUS synchronisers
  // ----------------------------------------
  logic [5:0] strap_level;
  logic [NPORTS-1:0] vbus_above_4v;

  pin_sync #(
    .WIDTH(6)
  ) u_strap_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .pin({port2_power_out_charge_strap_in, port1_power_out_charge_strap_in, bus_mode_strap,
          power_enable_polarity_strap, ganged_strap, power_switching_strap_n}),
    .level(strap_level)
  );

  pin_sync #(
    .WIDTH(NPORTS)
  ) u_vbus_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .pin(vbus_above_4v_pin),
    .level(vbus_above_4v)
  );

  // ----------------------------------------
  // Strap capture sequence
  // ----------------------------------------
  // Capture comes once the synchroniser has settled after reset release, well
  // inside the strap hold window; the power pins are driven only after that
  // window, so the device never fights the board's strap resistors.
  strap_state_t strap_state;
  logic [7:0] strap_count;
  logic strap_capture;
  logic hold_over;

  assign strap_capture = (strap_state == ST_SETTLE) &&
                         (strap_count == 8'(`STRAP_SETTLE_CYCLES - 1));
  assign hold_over = (strap_state == ST_HOLD) &&
                     (strap_count == 8'(`STRAP_HOLD_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_state <= ST_SETTLE;
      strap_count <= 8'h00;
    end
    else if (ce)
    begin
      unique case (strap_state)
        ST_SETTLE:
        begin
          strap_count <= strap_capture ? 8'h00 : strap_count + 8'h01;
          if (strap_capture)
            strap_state <= ST_HOLD;
        end
        ST_HOLD:
        begin
          strap_count <= hold_over ? 8'h00 : strap_count + 8'h01;
          if (hold_over)
            strap_state <= ST_RUN;
        end
        ST_RUN:
          strap_count <= 8'h00;
        default:
          strap_state <= ST_SETTLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_mode <= 1'b0;
    else if (ce && strap_capture)
      bus_mode <= strap_level[3];
  end

  assign strap_done = (strap_state == ST_RUN);

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire cfg_wr_en = ce && cfg_wr;
  wire otp_en = ce && otp_load;
  wire wr_vid_lo = cfg_wr_en && (cfg_addr == `OFS_VENDOR_ID_LOW);
  wire wr_vid_hi = cfg_wr_en && (cfg_addr == `OFS_VENDOR_ID_HIGH);
  wire wr_pid_lo = cfg_wr_en && (cfg_addr == `OFS_PRODUCT_ID_LOW);
  wire wr_pid_hi = cfg_wr_en && (cfg_addr == `OFS_PRODUCT_ID_HIGH);
  wire wr_dev = cfg_wr_en && (cfg_addr == `OFS_DEVICE_CONFIG);
  wire wr_chg = cfg_wr_en && (cfg_addr == `OFS_CHARGE_SUPPORT);
  wire wr_rmv = cfg_wr_en && (cfg_addr == `OFS_PORT_REMOVABLE);
  wire wr_dev2 = cfg_wr_en && (cfg_addr == `OFS_DEVICE_CONFIG_TWO);
  wire wr_cpc = cfg_wr_en && (cfg_addr == `OFS_CHARGE_PORT_CTRL);

  // Mask of bits that one-time memory may set at an address; zero elsewhere
  function automatic logic [7:0] otp_mask(input logic [7:0] addr);
    unique case (addr)
      `OFS_VENDOR_ID_LOW, `OFS_VENDOR_ID_HIGH,
      `OFS_PRODUCT_ID_LOW, `OFS_PRODUCT_ID_HIGH: otp_mask = `OTP_MASK_ID;
      `OFS_PORT_REMOVABLE: otp_mask = `OTP_MASK_REMOVABLE;
      `OFS_DEVICE_CONFIG_TWO: otp_mask = `OTP_MASK_CONFIG_TWO;
      `OFS_CHARGE_PORT_CTRL: otp_mask = `OTP_MASK_CHARGE_CTRL;
      default: otp_mask = 8'h00;
    endcase
  endfunction : otp_mask

  wire [7:0] load_mask = otp_mask(otp_addr);
  // Removable bits are stored as 1 = removable, so one-time data is inverted
  wire [7:0] load_data = (otp_addr == `OFS_PORT_REMOVABLE) ? ~otp_data : otp_data;
  wire ld_hit = otp_en && (load_mask != 8'h00);

  // Merge one-time data into a register, touching only the permitted bits
  function automatic logic [7:0] merge(input logic [7:0] cur);
    merge = (cur & ~load_mask) | (load_data & load_mask);
  endfunction : merge

  // ----------------------------------------
  // Identifier registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vendor_id_low <= `RST_VENDOR_ID_LOW;
      vendor_id_high <= `RST_VENDOR_ID_HIGH;
      product_id_low <= `RST_PRODUCT_ID_LOW;
      product_id_high <= `RST_PRODUCT_ID_HIGH;
    end
    else
    begin
      // Register writes win over a one-time load in the same cycle
      if (wr_vid_lo)
        vendor_id_low <= cfg_wdata;
      else if (ld_hit && otp_addr == `OFS_VENDOR_ID_LOW)
        vendor_id_low <= merge(vendor_id_low);
      if (wr_vid_hi)
        vendor_id_high <= cfg_wdata;
      else if (ld_hit && otp_addr == `OFS_VENDOR_ID_HIGH)
        vendor_id_high <= merge(vendor_id_high);
      if (wr_pid_lo)
        product_id_low <= cfg_wdata;
      else if (ld_hit && otp_addr == `OFS_PRODUCT_ID_LOW)
        product_id_low <= merge(product_id_low);
      if (wr_pid_hi)
        product_id_high <= cfg_wdata;
      else if (ld_hit && otp_addr == `OFS_PRODUCT_ID_HIGH)
        product_id_high <= merge(product_id_high);
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      device_config <= `RST_DEVICE_CONFIG;
      charge_support <= `RST_CHARGE_SUPPORT;
      port_removable_config <= `RST_PORT_REMOVABLE;
      device_config_two <= `RST_DEVICE_CONFIG_TWO;
      charge_port_control <= `RST_CHARGE_PORT_CTRL;
    end
    else
    begin
      if (wr_dev)
        device_config <= cfg_wdata;
      else if (ce && strap_capture)
      begin
        device_config[`BIT_PWR_SWITCH_N] <= strap_level[0];
        device_config[`BIT_GANGED] <= strap_level[1];
      end
      if (wr_chg)
        charge_support <= {4'h0, cfg_wdata[3:0]};
      else if (ce && strap_capture)
        charge_support[1:0] <= strap_level[5:4];
      if (wr_rmv)
        port_removable_config <= cfg_wdata;
      else if (ld_hit && otp_addr == `OFS_PORT_REMOVABLE)
        port_removable_config <= merge(port_removable_config);
      if (wr_dev2)
        device_config_two <= cfg_wdata;
      else if (ld_hit && otp_addr == `OFS_DEVICE_CONFIG_TWO)
        device_config_two <= merge(device_config_two);
      else if (ce && strap_capture)
        device_config_two[`BIT_POLARITY] <= strap_level[2];
      if (wr_cpc)
        charge_port_control <= cfg_wdata;
      else if (ld_hit && otp_addr == `OFS_CHARGE_PORT_CTRL)
        charge_port_control <= merge(charge_port_control);
    end
  end

  // ----------------------------------------
  // Battery charging
  // ----------------------------------------
  charge_mode_t port_mode [NPORTS];

  charge_mode_select #(
    .NPORTS(NPORTS)
  ) u_charge (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .port_charge_enable(charge_support[NPORTS-1:0]),
    .auto_charge_disable_n(device_config_two[`BIT_AUTO_DISABLE_N]),
    .vbus_above_4v(vbus_above_4v),
    .dcp_device_seen(dcp_device_seen),
    .port_mode(port_mode),
    .port_signal(port_signal)
  );

  assign divider_level_10w = device_config_two[`BIT_DIV_HIGH];
  assign power_on_delay_sel = charge_port_control[`FLD_PON_DELAY_MSB:`FLD_PON_DELAY_LSB];
  assign port_removable = port_removable_config[NPORTS-1:0];

  // ----------------------------------------
  // Power switch control
  // ----------------------------------------
  // Without switching the ports are simply kept powered.
  wire switching_on = !device_config[`BIT_PWR_SWITCH_N];
  wire ganged = device_config[`BIT_GANGED];
  wire active_high = device_config_two[`BIT_POLARITY];
  wire [1:0] port_on = !switching_on ? 2'b11 :
                       ganged ? {2{|port_power_request}} :
                       port_power_request;
  logic [1:0] power_level;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      power_level <= 2'b00;
    else if (ce)
      power_level <= active_high ? port_on : ~port_on;
  end

  assign port1_power_out_charge_strap_out = power_level[0];
  assign port2_power_out_charge_strap_out = power_level[1];
  assign port1_power_out_charge_strap_oe = strap_done;
  assign port2_power_out_charge_strap_oe = strap_done;

  // ----------------------------------------
  // Downstream speed limits
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ds_superspeed_enable <= 1'b0;
      ds_highspeed_enable <= 1'b0;
    end
    else if (ce)
    begin
      ds_superspeed_enable <= (upstream_speed == LINK_SUPER);
      ds_highspeed_enable <= (upstream_speed != LINK_FULL_LOW);
    end
  end

  // ----------------------------------------
  // One-time programming requests
  // ----------------------------------------
  wire [7:0] prog_mask = otp_mask(usb_otp_addr);
  wire [7:0] prog_data = (usb_otp_addr == `OFS_PORT_REMOVABLE) ? ~usb_otp_data : usb_otp_data;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      otp_prog_strobe <= 1'b0;
      otp_prog_reject <= 1'b0;
      otp_prog_addr <= 8'h00;
      otp_prog_data <= 8'h00;
    end
    else if (ce)
    begin
      otp_prog_strobe <= usb_otp_req && (prog_mask != 8'h00);
      otp_prog_reject <= usb_otp_req && (prog_mask == 8'h00);
      if (usb_otp_req && prog_mask != 8'h00)
      begin
        otp_prog_addr <= usb_otp_addr;
        // The request carries register sense; memory keeps removable inverted
        otp_prog_data <= prog_data & prog_mask;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [3:0] mode_status = {port_mode[1], port_mode[0]};
  logic [7:0] read_mux;

  always_comb
  begin
    unique case (cfg_addr)
      `OFS_VENDOR_ID_LOW: read_mux = vendor_id_low;
      `OFS_VENDOR_ID_HIGH: read_mux = vendor_id_high;
      `OFS_PRODUCT_ID_LOW: read_mux = product_id_low;
      `OFS_PRODUCT_ID_HIGH: read_mux = product_id_high;
      `OFS_DEVICE_CONFIG: read_mux = device_config;
      `OFS_CHARGE_SUPPORT: read_mux = {mode_status, charge_support[3:0]};
      `OFS_PORT_REMOVABLE: read_mux = port_removable_config;
      `OFS_DEVICE_CONFIG_TWO: read_mux = device_config_two;
      `OFS_CHARGE_PORT_CTRL: read_mux = charge_port_control;
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cfg_rdata <= 8'h00;
    else if (ce && cfg_rd)
      cfg_rdata <= read_mux;
  end

endmodule : hub_port_charge_power_config

// ### hw/pin_sync.sv
// Three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Pins
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          level[i] <= 1'b0;
        end
        else if (ce)
        begin
          stage1[i] <= pin[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          // Stage one is never looked at here: it may be metastable
          if (stage2[i] == stage3[i])
            level[i] <= stage3[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// ### include/hub_cfg_params.svh
// Register offsets, field positions, reset values and timing counts of the hub configuration block
`ifndef HUB_CFG_PARAMS_SVH
`define HUB_CFG_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_VENDOR_ID_LOW 8'h01
`define OFS_VENDOR_ID_HIGH 8'h02
`define OFS_PRODUCT_ID_LOW 8'h03
`define OFS_PRODUCT_ID_HIGH 8'h04
`define OFS_DEVICE_CONFIG 8'h05
`define OFS_CHARGE_SUPPORT 8'h06
`define OFS_PORT_REMOVABLE 8'h07
`define OFS_DEVICE_CONFIG_TWO 8'h0A
`define OFS_CHARGE_PORT_CTRL 8'hF2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_GANGED 3
`define BIT_PWR_SWITCH_N 4
`define BIT_AUTO_DISABLE_N 1
`define BIT_POLARITY 3
`define BIT_DIV_HIGH 4
`define FLD_PON_DELAY_MSB 3
`define FLD_PON_DELAY_LSB 1
`define FLD_STATUS_LSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_VENDOR_ID_LOW 8'h00
`define RST_VENDOR_ID_HIGH 8'h00
`define RST_PRODUCT_ID_LOW 8'h00
`define RST_PRODUCT_ID_HIGH 8'h00
`define RST_DEVICE_CONFIG 8'h00
`define RST_CHARGE_SUPPORT 8'h00
`define RST_PORT_REMOVABLE 8'h03
`define RST_DEVICE_CONFIG_TWO 8'h00
`define RST_CHARGE_PORT_CTRL 8'h00

// ----------------------------------------
// Fields that one-time memory may set
// ----------------------------------------
`define OTP_MASK_ID 8'hFF
`define OTP_MASK_REMOVABLE 8'h03
`define OTP_MASK_CONFIG_TWO 8'h12
`define OTP_MASK_CHARGE_CTRL 8'h0E

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define STRAP_HOLD_NS 100
`define STRAP_HOLD_CYCLES ((`STRAP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE_CYCLES 5

`endif

// ### include/hub_cfg_pkg.sv
// Types shared by the hub configuration block
package hub_cfg_pkg;

  typedef enum logic [1:0] {
    CHG_NONE = 2'b00,
    CHG_AUTO = 2'b01,
    CHG_DCP = 2'b10,
    CHG_CDP = 2'b11
  } charge_mode_t;

  typedef enum logic [1:0] {
    SIG_OFF = 2'b00,
    SIG_DIVIDER = 2'b01,
    SIG_DCP = 2'b10,
    SIG_CDP = 2'b11
  } charge_signal_t;

  typedef enum logic [1:0] {
    LINK_SUPER = 2'b00,
    LINK_HIGH = 2'b01,
    LINK_FULL_LOW = 2'b10,
    LINK_NONE = 2'b11
  } link_speed_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } strap_state_t;

endpackage : hub_cfg_pkg

// ### verif/hub_cfg_chk.sv
// Port-level checker of the hub configuration block
`timescale 1ns/100ps
module hub_cfg_chk
  import hub_cfg_pkg::*;
#(
  parameter int NPORTS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Watched ports
  input wire logic cfg_wr,
  input wire logic otp_load,
  input wire logic [7:0] otp_addr,
  input wire logic [7:0] otp_data,
  input wire logic usb_otp_req,
  input wire logic [7:0] usb_otp_addr,
  input wire logic [7:0] usb_otp_data,
  input wire logic otp_prog_strobe,
  input wire logic [7:0] otp_prog_data,
  input wire logic otp_prog_reject,
  input wire logic strap_done,
  input wire logic port1_power_out_charge_strap_oe,
  input wire logic [NPORTS-1:0] port_removable,
  input wire logic divider_level_10w,
  input wire link_speed_t upstream_speed,
  input wire logic ds_superspeed_enable,
  input wire logic ds_highspeed_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ss_follow_a: assert property (ce |=> ds_superspeed_enable == ($past(upstream_speed) == LINK_SUPER))
    else $error("superspeed enable wrong");
  hs_follow_a: assert property (ce |=> ds_highspeed_enable == ($past(upstream_speed) != LINK_FULL_LOW))
    else $error("highspeed enable wrong");
  pin_drive_a: assert property (port1_power_out_charge_strap_oe == strap_done)
    else $error("pin driven before strap window closed");
  done_stays_a: assert property (strap_done |=> strap_done) else $error("strap done dropped");
  prog_mask_a: assert property (ce && usb_otp_req && usb_otp_addr == 8'h0A
    |=> otp_prog_strobe && otp_prog_data == ($past(usb_otp_data) & 8'h12)) else $error("program data not masked");
  prog_refuse_a: assert property (ce && usb_otp_req && usb_otp_addr == 8'h05
    |=> otp_prog_reject && !otp_prog_strobe) else $error("locked address programmed");
  strobe_cause_a: assert property (otp_prog_strobe |-> $past(usb_otp_req)) else $error("stray strobe");
  rmbl_invert_a: assert property (ce && otp_load && otp_addr == 8'h07 && !cfg_wr
    |=> port_removable == ~$past(otp_data[1:0])) else $error("removable not inverted");
  div_cause_a: assert property ($changed(divider_level_10w) |-> $past(cfg_wr || otp_load))
    else $error("divider level moved alone");
  cover property (otp_prog_reject);
  cover property (otp_load && otp_addr == 8'h07);
  cover property ($rose(strap_done));
endmodule : hub_cfg_chk
bind hub_port_charge_power_config hub_cfg_chk #(.NPORTS(NPORTS)) chk (.clk, .resetn, .ce, .cfg_wr, .otp_load,
  .otp_addr, .otp_data, .usb_otp_req, .usb_otp_addr, .usb_otp_data, .otp_prog_strobe, .otp_prog_data,
  .otp_prog_reject, .strap_done, .port1_power_out_charge_strap_oe, .port_removable, .divider_level_10w,
  .upstream_speed, .ds_superspeed_enable, .ds_highspeed_enable);

// ### verif/hub_far_side.sv
// Board side: strap resistors, power switches and attached portable devices
`timescale 1ns/100ps
module hub_far_side #(
  parameter bit ACTIVE_HIGH = 1'b1
) (
  // Power enable pins
  input wire logic [1:0] pwr_out,
  input wire logic [1:0] pwr_oe,
  // Board straps and devices
  input wire logic [1:0] charge_strap,
  input wire logic [1:0] dcp_want,
  // Resolved pins and port status
  output logic [1:0] pin_level,
  output logic [1:0] vbus_high,
  output logic [1:0] dcp_seen
);
  // Strap resistors only set the level while the hub leaves the pin alone
  assign pin_level = (pwr_oe & pwr_out) | (~pwr_oe & charge_strap);
  // Switches have a fixed sense, so a wrong polarity inverts VBUS
  assign vbus_high = pwr_oe & (ACTIVE_HIGH ? pwr_out : ~pwr_out);
  assign dcp_seen = dcp_want & vbus_high;
endmodule : hub_far_side

// ### verif/hub_port_charge_power_config_bench.sv
// Self-checking bench of the hub configuration block
`timescale 1ns/100ps
module hub_port_charge_power_config_bench;
  import hub_cfg_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, otp_load = 1'b0, usb_otp_req = 1'b0;
  logic [7:0] addr = 8'h00, data = 8'h00, cfg_rdata, otp_prog_addr, otp_prog_data;
  logic otp_prog_strobe, otp_prog_reject, bus_mode, strap_done, divider_level_10w, ds_ss, ds_hs;
  logic p1_out, p1_oe, p2_out, p2_oe;
  logic [2:0] power_on_delay_sel;
  logic [1:0] port_removable, pin_level, vbus, dcp_seen, board_charge = 2'h2, req = 2'h0, dcp_want = 2'h0;
  charge_signal_t port_signal [2];
  link_speed_t upstream_speed = LINK_SUPER;
  int mismatches = 0, check_count = 0;
  logic [7:0] ra [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0A, 8'hF2, 8'h08};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h42, 8'h03, 8'h08, 8'h00, 8'h00};
  logic [7:0] tdc [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
  logic [7:0] tdc2 [7] = '{8'h08, 8'h08, 8'h0A, 8'h0A, 8'h02, 8'h0A, 8'h0A};
  logic [1:0] treq [7] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1, 2'h0};
  logic [1:0] tout [7] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h3, 2'h3};
  charge_signal_t tsig [7] = '{SIG_DIVIDER, SIG_DCP, SIG_CDP, SIG_DCP, SIG_DCP, SIG_CDP, SIG_CDP};
  always #4 clk = ~clk;
  // Straps tied as the board would fit them: switching on, ganged, active high, port 2 charging
  hub_port_charge_power_config dut (.clk(clk), .resetn(resetn), .ce(1'b1), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(addr), .cfg_wdata(data), .cfg_rdata(cfg_rdata), .otp_load(otp_load), .otp_addr(addr),
    .otp_data(data), .usb_otp_req(usb_otp_req), .usb_otp_addr(addr), .usb_otp_data(data),
    .otp_prog_strobe(otp_prog_strobe), .otp_prog_addr(otp_prog_addr), .otp_prog_data(otp_prog_data),
    .otp_prog_reject(otp_prog_reject), .power_switching_strap_n(1'b0), .ganged_strap(1'b1),
    .power_enable_polarity_strap(1'b1), .bus_mode_strap(1'b1), .bus_mode(bus_mode),
    .strap_done(strap_done), .port1_power_out_charge_strap_in(pin_level[0]),
    .port1_power_out_charge_strap_out(p1_out), .port1_power_out_charge_strap_oe(p1_oe),
    .port2_power_out_charge_strap_in(pin_level[1]), .port2_power_out_charge_strap_out(p2_out),
    .port2_power_out_charge_strap_oe(p2_oe), .port_power_request(req), .vbus_above_4v_pin(vbus),
    .dcp_device_seen(dcp_seen), .port_signal(port_signal), .divider_level_10w(divider_level_10w),
    .power_on_delay_sel(power_on_delay_sel), .port_removable(port_removable), .upstream_speed(upstream_speed),
    .ds_superspeed_enable(ds_ss), .ds_highspeed_enable(ds_hs));
  hub_far_side far (.pwr_out({p2_out, p1_out}), .pwr_oe({p2_oe, p1_oe}), .charge_strap(board_charge),
    .dcp_want(dcp_want), .pin_level(pin_level), .vbus_high(vbus), .dcp_seen(dcp_seen));
  task automatic end_of_test;
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk_sig(input charge_signal_t got, input charge_signal_t exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t port signal %0d expected %0d", $time, got, exp);
    end
  endtask : chk_sig
  // Kind 0 write, 1 read, 2 one-time load, 3 vendor program request
  task automatic bus(input int kind, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= (kind == 0);
    cfg_rd <= (kind == 1);
    otp_load <= (kind == 2);
    usb_otp_req <= (kind == 3);
    addr <= a;
    data <= d;
    @(posedge clk);
    {cfg_wr, cfg_rd, otp_load, usb_otp_req} <= 4'h0;
    #1;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1, a, 8'h00);
    chk8(cfg_rdata, exp);
  endtask : rd
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 40 && strap_done !== 1'b1; i++) @(posedge clk);
    #1;
    chk8({bus_mode, strap_done, p2_oe, p1_oe}, 8'h0F);
    bus(0, 8'h08, 8'hFF);
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    bus(0, 8'h01, 8'hA5);
    rd(8'h01, 8'hA5);
    bus(2, 8'h07, 8'h01);
    chk8(port_removable, 8'h02);
    bus(2, 8'h05, 8'hFF);
    rd(8'h05, 8'h08);
    bus(2, 8'h0A, 8'hFF);
    rd(8'h0A, 8'h1A);
    chk8(divider_level_10w, 8'h01);
    bus(2, 8'hF2, 8'hFF);
    chk8(power_on_delay_sel, 8'h07);
    bus(2, 8'h02, 8'h5A);
    rd(8'h02, 8'h5A);
    bus(3, 8'h07, 8'h01);
    chk8(otp_prog_data, 8'h02);
    bus(3, 8'h05, 8'hFF);
    chk8({otp_prog_strobe, otp_prog_reject}, 8'h01);
    chk8(otp_prog_addr, 8'h07);
    bus(3, 8'h0A, 8'hFF);
    chk8({otp_prog_strobe, otp_prog_reject}, 8'h02);
    chk8(otp_prog_addr, 8'h0A);
    chk8(otp_prog_data, 8'h12);
    bus(0, 8'h06, 8'h01);
    for (int i = 0; i < 7; i++)
    begin
      bus(0, 8'h05, tdc[i]);
      bus(0, 8'h0A, tdc2[i]);
      req <= treq[i];
      dcp_want <= (i == 1) ? 2'h1 : 2'h0;
      repeat (8) @(posedge clk);
      #1;
      chk8({p2_out, p1_out}, tout[i]);
      chk_sig(port_signal[0], tsig[i]);
      chk_sig(port_signal[1], SIG_OFF);
    end
    rd(8'h06, 8'h31);
    for (int s = 0; s < 4; s++)
    begin
      upstream_speed <= link_speed_t'(s);
      @(posedge clk);
      @(posedge clk);
      #1;
      chk8({ds_ss, ds_hs}, {6'h0, s == 0, s != 2});
    end
    end_of_test;
  end
endmodule : hub_port_charge_power_config_bench
